/* File: core/gp5_cfg.svh */
// Constants of the five-bit port: offsets, fields, reset values
`ifndef GP5_CFG_SVH
`define GP5_CFG_SVH

// ---------------------------------------------------------------
// Register offsets, bank select bit as address bit 7
// ---------------------------------------------------------------
`define GP5_ADDR_PIN_DATA 8'h05
`define GP5_ADDR_DIRECTION 8'h85
`define GP5_ADDR_CMP_CTRL 8'h1f
`define GP5_ADDR_VREF_CTRL 8'h9f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GP5_CMP_MODE_LSB 0
`define GP5_CMP_MODE_MSB 2
`define GP5_VREF_EN_BIT 7
`define GP5_VREF_PIN_BIT 6

// ---------------------------------------------------------------
// Comparator mode encodings
// ---------------------------------------------------------------
`define GP5_MODE_RESET 3'h0
`define GP5_MODE_PIN_OUT 3'h6
`define GP5_MODE_OFF 3'h7

// ---------------------------------------------------------------
// Analogue input masks on pins a3..a0
// ---------------------------------------------------------------
`define GP5_AMASK_ALL 5'h0f
`define GP5_AMASK_PIN_OUT 5'h07
`define GP5_AMASK_NONE 5'h00

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define GP5_RST_DIRECTION 5'h1f
`define GP5_RST_LATCH 5'h00
`define GP5_RST_CMP_CTRL 8'h00
`define GP5_RST_VREF_CTRL 8'h00

`endif

/* File: core/gp5_pkg.sv */
// Types shared by the five-bit port
package gp5_pkg;

   typedef logic [4:0] gp5_pins_t;

   typedef enum logic [2:0] {
      GP5_SEL_NONE = 3'b000,
      GP5_SEL_DATA = 3'b001,
      GP5_SEL_DIR = 3'b010,
      GP5_SEL_CMC = 3'b011,
      GP5_SEL_VRC = 3'b100
   } gp5_sel_t;

endpackage : gp5_pkg

/* File: core/gp5_port.sv */
// Five-bit general purpose port with direction register
//
// Overview of operation
// [R01] Five-bit output latch, one bit per pin
// [R02] Pin a4 output is open drain only
// [R03] Pin a4 level feeds timer external clock
// [R04] Other pins drive high and low
// [R05] Direction bit one: driver high impedance
// [R06] Direction bit zero: pin drives latch value
// [R07] Data read returns pins; write sets latch
// [R08] Writes store whole latch, read-modify-write
// [R09] Analogue input pins read as zero
// [R10] Pin function set by comparator, vref controls
// [R11] Reset: inputs, digital paths off, grounded
// [R12] Direction still steers drivers in analogue use
// [R13] Pin a2 carries vref; keep it input
// [R14] Comparator output mode drives a3, a4
// [R15] Enabled peripheral takes pin from port use
// [R16] Direction reached only in upper bank
// [R17] Bits 7 to 5 read zero, ignore writes
// [R18] Pin inputs synchronised before being read
`timescale 1ns/1ps
`include "gp5_cfg.svh"

module gp5_port #(
   parameter int WIDTH = 5
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [6:0] addr,
   input wire logic bank_select_bit,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   input wire logic cmp1_result,
   input wire logic cmp2_result,
   output logic [2:0] cmp_mode,
   output logic cmp_inputs_grounded,
   output logic vref_enable,
   output logic vref_on_pin_a2,
   output logic timer_external_clock_in
);

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   function automatic gp5_pkg::gp5_sel_t decode(input logic bank,
                                                input logic [6:0] a);
      logic [7:0] full;
      full = {bank, a};
      case (full)
         `GP5_ADDR_PIN_DATA: decode = gp5_pkg::GP5_SEL_DATA;
         `GP5_ADDR_DIRECTION: decode = gp5_pkg::GP5_SEL_DIR;
         `GP5_ADDR_CMP_CTRL: decode = gp5_pkg::GP5_SEL_CMC;
         `GP5_ADDR_VREF_CTRL: decode = gp5_pkg::GP5_SEL_VRC;
         default: decode = gp5_pkg::GP5_SEL_NONE;
      endcase
   endfunction : decode

   // Pins that currently act as analogue comparator inputs
   function automatic logic [4:0] analogue_mask(input logic [2:0] m);
      case (m)
         `GP5_MODE_OFF: analogue_mask = `GP5_AMASK_NONE;
         `GP5_MODE_PIN_OUT: analogue_mask = `GP5_AMASK_PIN_OUT;
         default: analogue_mask = `GP5_AMASK_ALL;
      endcase
   endfunction : analogue_mask

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [WIDTH-1:0] sync1;
   logic [WIDTH-1:0] sync2;
   logic [WIDTH-1:0] latch;
   logic [WIDTH-1:0] dir;
   logic [7:0] cmc;
   logic [7:0] vrc;
   logic [WIDTH-1:0] next_sync1;
   logic [WIDTH-1:0] next_sync2;
   logic [WIDTH-1:0] next_latch;
   logic [WIDTH-1:0] next_dir;
   logic [7:0] next_cmc;
   logic [7:0] next_vrc;
   logic [7:0] next_rdata;
   logic [WIDTH-1:0] next_pin_out;
   logic [WIDTH-1:0] next_pin_oe;
   logic next_tclk;
   logic next_grounded;
   logic next_vref_en;
   logic next_vref_a2;
   gp5_pkg::gp5_sel_t sel;
   logic [2:0] mode;
   logic [4:0] amask;

   assign sel = decode(bank_select_bit, addr); // see [R16]
   assign mode = cmc[`GP5_CMP_MODE_MSB:`GP5_CMP_MODE_LSB]; // see [R10]
   assign amask = analogue_mask(mode);

   // ------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------
   always_comb begin
      next_sync1 = pin_in; // see [R18]
      next_sync2 = sync1;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_comb begin
      next_latch = latch;
      next_dir = dir;
      next_cmc = cmc;
      next_vrc = vrc;
      next_rdata = 8'h00;
      if (wr) begin
         case (sel)
            // Whole latch stored, upper bits dropped
            gp5_pkg::GP5_SEL_DATA: next_latch = wdata[WIDTH-1:0]; // see [R08]
            gp5_pkg::GP5_SEL_DIR: next_dir = wdata[WIDTH-1:0]; // see [R17]
            gp5_pkg::GP5_SEL_CMC: next_cmc = wdata;
            gp5_pkg::GP5_SEL_VRC: next_vrc = wdata;
            default: begin
            end
         endcase
      end
      if (rd) begin
         case (sel)
            gp5_pkg::GP5_SEL_DATA:
               next_rdata = {3'h0, sync2 & ~amask}; // see [R07] [R09]
            gp5_pkg::GP5_SEL_DIR: next_rdata = {3'h0, dir}; // see [R17]
            gp5_pkg::GP5_SEL_CMC: next_rdata = cmc;
            gp5_pkg::GP5_SEL_VRC: next_rdata = vrc;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch <= `GP5_RST_LATCH; // see [R01]
         dir <= `GP5_RST_DIRECTION; // see [R11]
         cmc <= `GP5_RST_CMP_CTRL; // see [R11]
         vrc <= `GP5_RST_VREF_CTRL;
         rdata <= 8'h00;
      end else begin
         latch <= next_latch; // see [R01] [R07]
         dir <= next_dir;
         cmc <= next_cmc;
         vrc <= next_vrc;
         rdata <= next_rdata;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers and peripheral routing
   // ------------------------------------------------------------
   always_comb begin
      next_pin_out = latch; // see [R06] [R04]
      next_pin_oe = ~dir; // see [R05] [R12]
      if (mode == `GP5_MODE_PIN_OUT) begin
         // Comparator results replace the latch on a3 and a4
         next_pin_out[3] = cmp1_result; // see [R14] [R15]
         next_pin_out[4] = cmp2_result; // see [R14]
      end
      // Pin a4 only ever pulls low
      next_pin_oe[4] = ~dir[4] & ~next_pin_out[4]; // see [R02]
      next_pin_out[4] = 1'b0; // see [R02]
      next_tclk = sync2[4]; // see [R03]
      next_grounded = (mode == `GP5_MODE_RESET); // see [R11]
      next_vref_en = vrc[`GP5_VREF_EN_BIT];
      next_vref_a2 = vrc[`GP5_VREF_EN_BIT]
                     & vrc[`GP5_VREF_PIN_BIT]; // see [R13]
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pin_out <= '0;
         pin_oe <= '0;
         cmp_mode <= `GP5_MODE_RESET;
         cmp_inputs_grounded <= 1'b1;
         vref_enable <= 1'b0;
         vref_on_pin_a2 <= 1'b0;
         timer_external_clock_in <= 1'b0;
      end else begin
         pin_out <= next_pin_out;
         pin_oe <= next_pin_oe;
         cmp_mode <= mode; // see [R10]
         cmp_inputs_grounded <= next_grounded; // see [R11]
         vref_enable <= next_vref_en;
         vref_on_pin_a2 <= next_vref_a2; // see [R13]
         timer_external_clock_in <= next_tclk; // see [R03]
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_a4_never_high: assert property ( // see [R02]
      @(posedge clk) disable iff (!nrst)
      !pin_out[4] && !(pin_oe[4] && $past(dir[4])))
      else $error("pin a4 drives high or drives while input");

   a_dir_hiz: assert property ( // see [R05]
      @(posedge clk) disable iff (!nrst)
      $past(nrst) |-> (pin_oe[3:0] == ~$past(dir[3:0])))
      else $error("output enable does not follow direction");

   a_drive_latch: assert property ( // see [R06]
      @(posedge clk) disable iff (!nrst)
      ($past(nrst) && !$past(dir[0]) && !$past(dir[2]))
      |-> (pin_out[0] == $past(latch[0]))
          && (pin_out[2] == $past(latch[2])))
      else $error("driven pin differs from latch");

   a_write_latch: assert property ( // see [R08]
      @(posedge clk) disable iff (!nrst)
      (wr && sel == gp5_pkg::GP5_SEL_DATA)
      |=> (latch == $past(wdata[WIDTH-1:0]))
          ##1 (pin_out[2] == $past(latch[2])))
      else $error("port write not stored in latch");

   a_read_pins: assert property ( // see [R07]
      @(posedge clk) disable iff (!nrst)
      (rd && sel == gp5_pkg::GP5_SEL_DATA && mode == `GP5_MODE_OFF)
      |=> (rdata == {3'h0, $past(sync2)}))
      else $error("port read not equal to pin levels");

   a_analog_zero: assert property ( // see [R09]
      @(posedge clk) disable iff (!nrst)
      (rd && sel == gp5_pkg::GP5_SEL_DATA && mode != `GP5_MODE_OFF)
      |=> (rdata[2:0] == 3'h0))
      else $error("analogue input pin reads non zero");

   a_upper_zero: assert property ( // see [R17]
      @(posedge clk) disable iff (!nrst)
      (rd && (sel == gp5_pkg::GP5_SEL_DATA || sel == gp5_pkg::GP5_SEL_DIR))
      |=> (rdata[7:5] == 3'h0))
      else $error("upper bits of port register not zero");

   a_bank_gate: assert property ( // see [R16]
      @(posedge clk) disable iff (!nrst)
      (wr && !bank_select_bit)
      |=> $stable(dir))
      else $error("direction written from lower bank");

   a_tclk_follow: assert property ( // see [R03]
      @(posedge clk) disable iff (!nrst)
      $past(nrst, 3) |-> (timer_external_clock_in == $past(pin_in[4], 3)))
      else $error("timer clock does not follow pin a4");

   a_cmp_out: assert property ( // see [R14]
      @(posedge clk) disable iff (!nrst)
      (mode == `GP5_MODE_PIN_OUT && !dir[3])
      |=> (pin_out[3] == $past(cmp1_result)) && pin_oe[3])
      else $error("comparator output missing on pin a3");

   a_reset_state: assert property ( // see [R11]
      @(posedge clk)
      $rose(nrst) |-> (dir == `GP5_RST_DIRECTION) && cmp_inputs_grounded
                      && (pin_oe == '0))
      else $error("reset state not all inputs and grounded");

   a_vref_pin: assert property ( // see [R13]
      @(posedge clk) disable iff (!nrst)
      (vrc[`GP5_VREF_EN_BIT] && vrc[`GP5_VREF_PIN_BIT]) |=> vref_on_pin_a2)
      else $error("voltage reference not routed to pin a2");

   a_vref_off: assert property ( // see [R13]
      @(posedge clk) disable iff (!nrst)
      !vrc[`GP5_VREF_EN_BIT] |=> !vref_enable && !vref_on_pin_a2)
      else $error("voltage reference flagged while disabled");

   a_latch_hold: assert property ( // see [R01]
      @(posedge clk) disable iff (!nrst)
      !(wr && sel == gp5_pkg::GP5_SEL_DATA) |=> $stable(latch))
      else $error("output latch changed without a port write");

   a_dir_hold: assert property ( // see [R16]
      @(posedge clk) disable iff (!nrst)
      !(wr && sel == gp5_pkg::GP5_SEL_DIR) |=> $stable(dir))
      else $error("direction changed without a direction write");

   a_dir_write: assert property ( // see [R16]
      @(posedge clk) disable iff (!nrst)
      (wr && sel == gp5_pkg::GP5_SEL_DIR)
      |=> (dir == $past(wdata[WIDTH-1:0])))
      else $error("direction write not stored");

   a_dir_read: assert property ( // see [R17]
      @(posedge clk) disable iff (!nrst)
      (rd && sel == gp5_pkg::GP5_SEL_DIR) |=> (rdata == {3'h0, $past(dir)}))
      else $error("direction read differs from register");

   a_read_idle: assert property ( // see [R07]
      @(posedge clk) disable iff (!nrst)
      !rd |=> (rdata == 8'h00))
      else $error("read data present without a read");

   a_unmapped_zero: assert property ( // see [R16]
      @(posedge clk) disable iff (!nrst)
      (rd && sel == gp5_pkg::GP5_SEL_NONE) |=> (rdata == 8'h00))
      else $error("unmapped address reads non zero");

   a_grounded_mode: assert property ( // see [R11]
      @(posedge clk) disable iff (!nrst)
      $past(nrst)
      |-> (cmp_inputs_grounded == ($past(mode) == `GP5_MODE_RESET)))
      else $error("grounding flag does not follow reset mode");

   a_mode_copy: assert property ( // see [R10]
      @(posedge clk) disable iff (!nrst)
      $past(nrst) |-> (cmp_mode == $past(mode)))
      else $error("comparator mode output lags its register");

   a_sync_delay: assert property ( // see [R18]
      @(posedge clk) disable iff (!nrst)
      ($past(nrst) && $past(nrst, 2)) |-> (sync2 == $past(pin_in, 2)))
      else $error("pin sample not two clocks behind pin");

   a_a4_pull: assert property ( // see [R02]
      @(posedge clk) disable iff (!nrst)
      (!dir[4] && !latch[4] && mode != `GP5_MODE_PIN_OUT) |=> pin_oe[4])
      else $error("pin a4 not pulled low for a low latch");

   a_a4_release: assert property ( // see [R02]
      @(posedge clk) disable iff (!nrst)
      (latch[4] && mode != `GP5_MODE_PIN_OUT) |=> !pin_oe[4])
      else $error("pin a4 driven for a high latch");

   a_cmp_a4: assert property ( // see [R14]
      @(posedge clk) disable iff (!nrst)
      (mode == `GP5_MODE_PIN_OUT && !dir[4])
      |=> (pin_oe[4] == !$past(cmp2_result)))
      else $error("comparator output missing on pin a4");

   a_drive_high: assert property ( // see [R04]
      @(posedge clk) disable iff (!nrst)
      (!dir[0] && latch[0]) |=> (pin_oe[0] && pin_out[0]))
      else $error("pin a0 does not drive a high level");

endmodule : gp5_port

/* File: dv/five_bit_port_with_direction_test.sv */
// Self-checking bench of the five-bit port
`timescale 1ns/1ps

module five_bit_port_with_direction_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [6:0] addr = 7'h00;
   logic bank = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [4:0] ext = 5'h00;
   logic c1 = 1'b0;
   logic c2 = 1'b0;
   logic [7:0] rdata, d;
   logic [4:0] pin_in, pin_out, pin_oe;
   logic cmp1_result, cmp2_result, grounded, vref_en, vref_a2, tclk;
   logic [2:0] cmp_mode;
   int errors = 0;
   int comparisons = 0;

   always #4 clk = ~clk;

   gp5_port dut (.clk(clk), .nrst(nrst), .addr(addr),
      .bank_select_bit(bank), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .cmp1_result(cmp1_result),
      .cmp2_result(cmp2_result), .cmp_mode(cmp_mode),
      .cmp_inputs_grounded(grounded), .vref_enable(vref_en),
      .vref_on_pin_a2(vref_a2), .timer_external_clock_in(tclk));

   gp5_pin_model pins (.ext_level(ext), .cmp1_level(c1),
      .cmp2_level(c2), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in), .cmp1_result(cmp1_result),
      .cmp2_result(cmp2_result));

   // ---------------------------------------------------------------
   // Bus and compare helpers
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [7:0] seen,
                      input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      {bank, addr} <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      {bank, addr} <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rd_reg

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask : settle

   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      rd_reg(8'h85, d);
      chk("direction", d, 8'h1f);
      chk("grounded", {7'h0, grounded}, 8'h01);
      chk("pin_oe", {3'h0, pin_oe}, 8'h00);
      chk("pin_out", {3'h0, pin_out}, 8'h00);
      chk("cmp_mode", {5'h0, cmp_mode}, 8'h00);
      chk("vref", {6'h0, vref_en, vref_a2}, 8'h00);
      @(posedge clk) ext <= 5'h1f;
      settle();
      rd_reg(8'h05, d);
      chk("data", d, 8'h10);
   endtask : t_reset

   task automatic t_outputs();
      wr_reg(8'h1f, 8'h07);
      wr_reg(8'h05, 8'h15);
      wr_reg(8'h85, 8'h00);
      @(posedge clk) ext <= 5'h10;
      settle();
      chk("cmp_mode", {5'h0, cmp_mode}, 8'h07);
      chk("grounded", {7'h0, grounded}, 8'h00);
      chk("pin_oe", {3'h0, pin_oe}, 8'h0f);
      chk("pin_out", {3'h0, pin_out}, 8'h05);
      rd_reg(8'h05, d);
      chk("data", d, 8'h15);
      wr_reg(8'h05, 8'hef);
      settle();
      chk("pin_oe", {3'h0, pin_oe}, 8'h1f);
      chk("pin_out", {3'h0, pin_out}, 8'h0f);
      rd_reg(8'h05, d);
      chk("data", d, 8'h0f);
   endtask : t_outputs

   task automatic t_inputs();
      wr_reg(8'h85, 8'hff);
      @(posedge clk) ext <= 5'h0a;
      settle();
      chk("pin_oe", {3'h0, pin_oe}, 8'h00);
      rd_reg(8'h85, d);
      chk("direction", d, 8'h1f);
      rd_reg(8'h05, d);
      chk("data", d, 8'h0a);
      chk("timer", {7'h0, tclk}, 8'h00);
      @(posedge clk) ext <= 5'h10;
      settle();
      chk("timer", {7'h0, tclk}, 8'h01);
   endtask : t_inputs

   task automatic t_bank();
      wr_reg(8'h05, 8'h00);
      rd_reg(8'h85, d);
      chk("direction", d, 8'h1f);
      wr_reg(8'h45, 8'hff);
      rd_reg(8'h45, d);
      chk("unmapped", d, 8'h00);
      wr_reg(8'h9f, 8'h80);
      settle();
      chk("vref", {6'h0, vref_en, vref_a2}, 8'h02);
      wr_reg(8'h9f, 8'hc0);
      settle();
      chk("vref", {6'h0, vref_en, vref_a2}, 8'h03);
   endtask : t_bank

   task automatic t_cmp_out();
      wr_reg(8'h1f, 8'h06);
      wr_reg(8'h85, 8'h00);
      @(posedge clk) begin
         c1 <= 1'b1;
         c2 <= 1'b0;
         ext <= 5'h1f;
      end
      settle();
      chk("pin_out3", {7'h0, pin_out[3]}, 8'h01);
      chk("pin_oe43", {6'h0, pin_oe[4:3]}, 8'h03);
      rd_reg(8'h05, d);
      chk("data", d, 8'h08);
      @(posedge clk) c2 <= 1'b1;
      settle();
      chk("pin_oe4", {7'h0, pin_oe[4]}, 8'h00);
      wr_reg(8'h85, 8'h18);
      settle();
      chk("pin_oe", {3'h0, pin_oe}, 8'h07);
      wr_reg(8'h1f, 8'h02);
      settle();
      chk("grounded", {7'h0, grounded}, 8'h00);
      chk("pin_out3", {7'h0, pin_out[3]}, 8'h00);
      rd_reg(8'h05, d);
      chk("data", d, 8'h10);
      wr_reg(8'h1f, 8'h00);
      settle();
      chk("grounded", {7'h0, grounded}, 8'h01);
   endtask : t_cmp_out

   task automatic t_reset_mid();
      wr_reg(8'h1f, 8'h07);
      wr_reg(8'h05, 8'h0f);
      wr_reg(8'h85, 8'h00);
      wr_reg(8'h9f, 8'hc0);
      settle();
      chk("pin_oe", {3'h0, pin_oe}, 8'h1f);
      chk("vref", {6'h0, vref_en, vref_a2}, 8'h03);
      @(posedge clk) nrst <= 1'b0;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(8'h85, d);
      chk("direction", d, 8'h1f);
      chk("grounded", {7'h0, grounded}, 8'h01);
      chk("pin_oe", {3'h0, pin_oe}, 8'h00);
      chk("pin_out", {3'h0, pin_out}, 8'h00);
      chk("vref", {6'h0, vref_en, vref_a2}, 8'h00);
      rd_reg(8'h05, d);
      chk("data", d, 8'h10);
   endtask : t_reset_mid

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_outputs();
      t_inputs();
      t_bank();
      t_cmp_out();
      t_reset_mid();
      tally_and_finish();
   end

   initial begin
      #100us;
      errors++;
      tally_and_finish();
   end
endmodule : five_bit_port_with_direction_test

/* File: dv/gp5_pin_model.sv */
// Model of the pins and comparators outside the port
`timescale 1ns/1ps

module gp5_pin_model (
   input wire logic [4:0] ext_level,
   input wire logic cmp1_level,
   input wire logic cmp2_level,
   input wire logic [4:0] pin_out,
   input wire logic [4:0] pin_oe,
   output logic [4:0] pin_in,
   output logic cmp1_result,
   output logic cmp2_result
);
   // ---------------------------------------------------------------
   // Wire levels
   // ---------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
      end
      // Open drain: only a low is driven, else the outside level
      pin_in[4] = pin_oe[4] ? 1'b0 : ext_level[4];
   end
   assign cmp1_result = cmp1_level;
   assign cmp2_result = cmp2_level;
endmodule : gp5_pin_model
